// File: pkg/ssc_regs.svh
// offsets, fields, reset values and codes of the standby and snooze controller
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
// ****************************************
// register word addresses
// ****************************************
`define SSC_ADDR_CTRL 4'h0
`define SSC_ADDR_STAT 4'h1
`define SSC_ADDR_OPER 4'h2
`define SSC_ADDR_REL 4'h3
// ****************************************
// control word fields
// ****************************************
`define SSC_CTRL_REQ_SW 0
`define SSC_CTRL_REQ_DEEP 1
// ****************************************
// snooze operation codes
// ****************************************
`define SSC_SNZ_CLEAR 16'h0000
`define SSC_OP_SER_BIT 1
`define SSC_OP_SER_XFER_BIT 0
`define SSC_OP_TMR_BIT 3
`define SSC_OP_TMR_XFER_BIT 2
`define SSC_OP_CONV_BIT 5
`define SSC_OP_CONV_XFER_BIT 4
`define SSC_OP_TOUCH_BIT 7
`define SSC_OP_REMOTE_BIT 9
`define SSC_OP_CMP_FAIL_BIT 11
`define SSC_OP_CMP_PASS_BIT 13
`define SSC_OP_XFER_EN_BIT 15
`define SSC_REL_SER_FULL_BIT 2
// ****************************************
// error codes and reset values
// ****************************************
`define SSC_ERR_NONE 2'h0
`define SSC_ERR_ILLEGAL 2'h1
`define SSC_ERR_OSC_STOP 2'h2
`define SSC_OPER_RESET 16'h0000
`endif

// File: pkg/ssc_pkg.sv
// types of the standby and snooze controller
package ssc_pkg;
  // power states of the chip
  typedef enum logic [1:0] {
    SSC_RUN = 2'b00,
    SSC_STANDBY = 2'b01,
    SSC_SNOOZE = 2'b10,
    SSC_DEEP = 2'b11
  } ssc_state_t;
  // blocking conditions as seen by the gate
  typedef struct packed {
    logic osc_stop_detect_en;
    logic dma_global_start_bit;
    logic transfer_ctrl_start_bit;
    logic flash_pe_mode;
    logic wdog_auto_start;
    logic wdog_option_lowpower_stop;
    logic wdog_reg_start;
    logic wdog_reg_lowpower_stop;
    logic volt_mon1_reset_sel;
    logic volt_mon2_reset_sel;
    logic osc_lock_loop_enable;
  } ssc_block_t;
  // peripheral events
  typedef struct packed {
    logic serial_receive_pin;
    logic serial_mismatch;
    logic serial_full;
    logic timer_match1;
    logic xfer_done;
    logic conv_done;
    logic touch_end_req;
    logic remote_clk_start;
    logic remote_clk_done;
    logic cmp_met;
    logic cmp_valid;
  } ssc_evt_t;
  // all module state
  typedef struct packed {
    ssc_state_t state;
    logic [15:0] oper;
    logic [15:0] rel;
    logic [15:0] oper_live;
    logic [1:0] err;
    logic rx_prev;
    logic rel_flag;
    logic conv_start;
    logic touch_start;
    logic [31:0] rdata;
    logic rvalid;
  } ssc_st_t;
endpackage

// File: rtl/ssc_ctrl.sv
// standby entry gate and snooze controller with an avalon-mm slave
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "ssc_regs.svh"
module ssc_ctrl
  import ssc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // avalon-mm slave, word addressed
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // chip condition levels
  input wire ssc_block_t block_in,
  // peripheral events
  input wire ssc_evt_t evt_in,
  input wire logic wake_irq,
  // power and peripheral outputs
  output ssc_state_t power_state,
  output logic clocks_stop,
  output logic snooze_xfer_allow,
  output logic conv_start,
  output logic touch_start,
  output logic snooze_release_irq
);
  // ****************************************
  // state
  // ****************************************
  ssc_st_t st_reg; // the whole registered state
  ssc_st_t st_next; // next value of it
  logic access; // a bus request is present
  logic deep_block; // any deep entry blocker
  logic sw_block; // any software standby blocker
  logic [15:0] wmask; // byte enables spread to bits
  logic [1:0] req; // entry request bits written
  logic rx_fall; // falling edge on serial receive pin
  logic enter_snz; // wake event for selected mode
  logic exit_snz; // back-to-standby event
  logic [15:0] op; // short alias of sampled selection

  // ****************************************
  // blocking conditions
  // ****************************************
  // deep entry checks every blocker but the lock loop; software standby only oscillator ones
  always_comb begin
    deep_block = block_in.osc_stop_detect_en
      | block_in.dma_global_start_bit
      | block_in.transfer_ctrl_start_bit
      | block_in.flash_pe_mode
      | (block_in.wdog_auto_start & ~block_in.wdog_option_lowpower_stop)
      | (block_in.wdog_reg_start & ~block_in.wdog_reg_lowpower_stop)
      | block_in.volt_mon1_reset_sel | block_in.volt_mon2_reset_sel;
    sw_block = block_in.osc_stop_detect_en | block_in.osc_lock_loop_enable;
  end

  // ****************************************
  // byte enable mask
  // ****************************************
  // only the low two lanes hold data
  generate
    for (genvar i = 0; i < 16; i++) begin : g_mask
      assign wmask[i] = avs_byteenable[i / 8];
    end
  endgenerate

  // ****************************************
  // snooze event decode
  // ****************************************
  // the selection bits are ored, so several paths may be armed at once
  always_comb begin
    op = st_reg.oper;
    rx_fall = st_reg.rx_prev & ~evt_in.serial_receive_pin;
    enter_snz = (op[`SSC_OP_SER_BIT] & rx_fall)
      | ((op[`SSC_OP_TMR_BIT] | op[`SSC_OP_CONV_BIT] | op[`SSC_OP_TOUCH_BIT]
      | op[`SSC_OP_CMP_FAIL_BIT] | op[`SSC_OP_CMP_PASS_BIT]) & evt_in.timer_match1)
      | (op[`SSC_OP_REMOTE_BIT] & evt_in.remote_clk_start);
    exit_snz = (op[`SSC_OP_SER_BIT] & evt_in.serial_mismatch)
      | (op[`SSC_OP_SER_XFER_BIT] & op[`SSC_OP_SER_BIT] & evt_in.xfer_done)
      | (op[`SSC_OP_TMR_XFER_BIT] & op[`SSC_OP_TMR_BIT] & evt_in.xfer_done)
      | (op[`SSC_OP_CONV_XFER_BIT] & op[`SSC_OP_CONV_BIT] & evt_in.xfer_done)
      | (op[`SSC_OP_TOUCH_BIT] & evt_in.touch_end_req)
      | (op[`SSC_OP_REMOTE_BIT] & evt_in.remote_clk_done)
      | (op[`SSC_OP_CMP_FAIL_BIT] & evt_in.cmp_valid & ~evt_in.cmp_met)
      | (op[`SSC_OP_CMP_PASS_BIT] & evt_in.cmp_valid & evt_in.cmp_met);
  end

  // ****************************************
  // next state
  // ****************************************
  // writes taken and answered in the same edge; reads taken at one edge, answered at the next
  always_comb begin
    st_next = st_reg;
    access = avs_read | avs_write;
    req = 2'h0;
    st_next.rvalid = 1'b0;
    st_next.conv_start = 1'b0;
    st_next.touch_start = 1'b0;
    st_next.rx_prev = evt_in.serial_receive_pin;
    // bus writes
    if (avs_write & ~st_reg.rvalid) begin
      case (avs_address)
        `SSC_ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            req = avs_writedata[1:0];
          end
        end
        `SSC_ADDR_STAT: begin
          // writing anything clears the error code
          st_next.err = `SSC_ERR_NONE;
        end
        `SSC_ADDR_OPER: begin
          st_next.oper_live = (st_reg.oper_live & ~wmask) | (avs_writedata[15:0] & wmask);
        end
        `SSC_ADDR_REL: begin
          st_next.rel = (st_reg.rel & ~wmask) | (avs_writedata[15:0] & wmask);
        end
        default: begin
          // unmapped: accepted and ignored
        end
      endcase
    end
    // reads return data one cycle later
    if (avs_read & ~st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      case (avs_address)
        `SSC_ADDR_STAT: st_next.rdata = {28'h0, st_reg.state, st_reg.err};
        `SSC_ADDR_OPER: st_next.rdata = {16'h0, st_reg.oper_live};
        `SSC_ADDR_REL: st_next.rdata = {16'h0, st_reg.rel};
        default: st_next.rdata = 32'h0;
      endcase
    end
    // power state machine
    case (st_reg.state)
      SSC_RUN: begin
        if (req[`SSC_CTRL_REQ_DEEP]) begin
          if (deep_block) begin
            // stay running, clocks untouched
            st_next.err = block_in.osc_stop_detect_en ? `SSC_ERR_OSC_STOP : `SSC_ERR_ILLEGAL;
          end else begin
            st_next.state = SSC_DEEP;
            st_next.err = `SSC_ERR_NONE;
          end
        end else if (req[`SSC_CTRL_REQ_SW]) begin
          if (sw_block) begin
            st_next.err = block_in.osc_stop_detect_en ? `SSC_ERR_OSC_STOP : `SSC_ERR_ILLEGAL;
          end else begin
            st_next.state = SSC_STANDBY;
            st_next.oper = st_reg.oper_live;
            st_next.err = `SSC_ERR_NONE;
          end
        end
      end
      SSC_STANDBY: begin
        if (wake_irq) begin
          st_next.state = SSC_RUN;
        end else if (enter_snz) begin
          st_next.state = SSC_SNOOZE;
          st_next.conv_start = (op[`SSC_OP_CONV_BIT] | op[`SSC_OP_CMP_FAIL_BIT]
            | op[`SSC_OP_CMP_PASS_BIT]) & evt_in.timer_match1;
          st_next.touch_start = op[`SSC_OP_TOUCH_BIT] & evt_in.timer_match1;
        end
      end
      SSC_SNOOZE: begin
        // pure stay modes have no exit term, so they remain here
        if (wake_irq | st_reg.rel_flag) begin
          st_next.state = SSC_RUN;
        end else if (exit_snz) begin
          st_next.state = SSC_STANDBY;
        end
      end
      SSC_DEEP: begin
        // only a wake leaves deep standby
        if (wake_irq) begin
          st_next.state = SSC_RUN;
        end
      end
      default: st_next.state = SSC_RUN;
    endcase
    // release interrupt, armed in every state while selected
    if (st_reg.rel == `SSC_SNZ_CLEAR) begin
      st_next.rel_flag = 1'b0;
    end else if (st_reg.rel[`SSC_REL_SER_FULL_BIT] & evt_in.serial_full) begin
      st_next.rel_flag = 1'b1;
    end else if (st_reg.state == SSC_RUN) begin
      // armed outside snooze, pulses in run too, held in standby and deep
      st_next.rel_flag = 1'b0;
    end
    if (!access) begin
      st_next.rdata = st_reg.rdata;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // clock enable low freezes everything
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // writes finish at once, reads wait one cycle for data
  assign avs_waitrequest = avs_read & ~st_reg.rvalid;
  assign avs_readdata = st_reg.rdata;
  assign avs_response = 2'h0;
  assign power_state = st_reg.state;
  assign clocks_stop = (st_reg.state == SSC_STANDBY) | (st_reg.state == SSC_DEEP);
  assign snooze_xfer_allow = (st_reg.state == SSC_SNOOZE) & st_reg.oper[`SSC_OP_XFER_EN_BIT];
  assign conv_start = st_reg.conv_start;
  assign touch_start = st_reg.touch_start;
  assign snooze_release_irq = st_reg.rel_flag;
endmodule

// File: testbench/ssc_ctrl_checker.sv
// port assertions of the standby gate and snooze controller
`timescale 1ns/10ps
module ssc_ctrl_checker
  import ssc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire ssc_block_t block_in,
  input wire ssc_state_t power_state,
  input wire logic clocks_stop,
  input wire logic snooze_xfer_allow,
  input wire logic conv_start,
  input wire logic touch_start
);
  // ****************************************
  // power requests seen while running
  // ****************************************
  logic req; // any request taken in run
  logic deep; // deep request, which wins over standby
  assign req = clk_en && avs_write && avs_address == 4'h0 && power_state == SSC_RUN;
  assign deep = req && avs_writedata[1];
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_osc; req && avs_writedata[1:0] != 2'h0 && block_in.osc_stop_detect_en |=> power_state == SSC_RUN; endproperty
  a_osc: assert property (p_osc) else $error("osc stop detect let entry through");
  property p_busy; deep && (block_in.dma_global_start_bit || block_in.transfer_ctrl_start_bit || block_in.flash_pe_mode)
    |=> power_state == SSC_RUN; endproperty
  a_busy: assert property (p_busy) else $error("deep entry while busy");
  property p_wdog; deep && ((block_in.wdog_auto_start && !block_in.wdog_option_lowpower_stop) ||
    (block_in.wdog_reg_start && !block_in.wdog_reg_lowpower_stop)) |=> power_state == SSC_RUN; endproperty
  a_wdog: assert property (p_wdog) else $error("deep entry with running watchdog");
  property p_volt; deep && (block_in.volt_mon1_reset_sel || block_in.volt_mon2_reset_sel) |=> power_state == SSC_RUN; endproperty
  a_volt: assert property (p_volt) else $error("deep entry with monitor reset on");
  property p_lock; req && avs_writedata[1:0] == 2'h1 && block_in.osc_lock_loop_enable
    |=> power_state == SSC_RUN && !clocks_stop; endproperty
  a_lock: assert property (p_lock) else $error("standby with lock loop on");
  property p_allow; snooze_xfer_allow |-> power_state == SSC_SNOOZE; endproperty
  a_allow: assert property (p_allow) else $error("transfers allowed outside snooze");
  property p_conv; conv_start |-> power_state == SSC_SNOOZE ##1 !conv_start; endproperty
  a_conv: assert property (p_conv) else $error("bad conversion start");
  property p_touch; touch_start |-> power_state == SSC_SNOOZE ##1 !touch_start; endproperty
  a_touch: assert property (p_touch) else $error("bad touch start");
  property p_entry; power_state == SSC_RUN |=> power_state != SSC_SNOOZE; endproperty
  a_entry: assert property (p_entry) else $error("snooze entered from run");
endmodule
bind ssc_ctrl ssc_ctrl_checker i_ssc_ctrl_checker (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata), .block_in(block_in),
  .power_state(power_state), .clocks_stop(clocks_stop), .snooze_xfer_allow(snooze_xfer_allow),
  .conv_start(conv_start), .touch_start(touch_start));

// File: testbench/ssc_periph_model.sv
// peripheral side model: bench commands become event pulses
`timescale 1ns/10ps
module ssc_periph_model
  import ssc_pkg::*;
(
  input wire logic clock,
  input wire logic [3:0] fire,
  output ssc_evt_t evt
);
  logic [1:0] low_cnt = 2'h0; // cycles the receive pin stays low
  initial evt = 11'h400;
  // ****************************************
  // one event per command, except that cmp_met comes with cmp_valid; pin idles high
  // ****************************************
  always @(posedge clock) begin
    evt <= '0;
    evt.serial_receive_pin <= low_cnt == 2'h0 && fire != 4'h1;
    low_cnt <= fire == 4'h1 ? 2'h3 : (low_cnt != 2'h0 ? low_cnt - 2'h1 : 2'h0);
    if (fire >= 4'h2 && fire <= 4'hA) begin
      evt[4'hB - fire] <= 1'b1;
    end
    if (fire >= 4'hA) begin
      evt.cmp_valid <= 1'b1;
    end
  end
endmodule

// File: testbench/ssc_ctrl_bench.sv
// self-checking bench of the standby gate and snooze controller
`timescale 1ns/10ps
`include "ssc_regs.svh"
module ssc_ctrl_bench
  import ssc_pkg::*;
;
  logic clock = 0, reset_n = 0, avs_read = 0, avs_write = 0, wake_irq = 0;
  logic [3:0] avs_address = 4'h0, fire = 4'h0;
  logic [31:0] avs_writedata = 32'h0, rd, w, avs_readdata;
  logic avs_waitrequest, clocks_stop, snooze_xfer_allow, conv_start, touch_start, snooze_release_irq;
  logic [1:0] avs_response;
  ssc_block_t block_in = '0;
  ssc_evt_t evt;
  ssc_state_t power_state;
  int bad_count = 0, comparisons = 0, cycles = 0, conv_n = 0, touch_n = 0, irq_n = 0, c0, t0;
  // gate cases: condition, request, expected status {state, err}
  logic [10:0] cond [11] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h010, 11'h004, 11'h002, 11'h001,
    11'h600, 11'h060};
  logic [1:0] req [11] = '{2, 2, 2, 2, 2, 2, 2, 2, 1, 2, 2};
  logic [3:0] st [11] = '{2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 4'hC};
  // snooze cases: code, entry, exit, state after exit, conv and touch pulses
  logic [31:0] tbl [11] = '{32'h0002_1210, 32'h0003_1510, 32'h0008_4520, 32'h000C_4510, 32'h0020_4522,
    32'h0030_4512, 32'h0080_4711, 32'h0200_8910, 32'h0800_4B12, 32'h2000_4A12, 32'h8008_4520};
  always #2 clock = ~clock;
  ssc_ctrl i_ssc_ctrl (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .block_in(block_in), .evt_in(evt), .wake_irq(wake_irq), .power_state(power_state), .clocks_stop(clocks_stop),
    .snooze_xfer_allow(snooze_xfer_allow), .conv_start(conv_start), .touch_start(touch_start),
    .snooze_release_irq(snooze_release_irq));
  ssc_periph_model i_ssc_periph_model (.clock(clock), .fire(fire), .evt(evt));
  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  always @(posedge clock) begin
    cycles <= cycles + 1;
    conv_n <= conv_n + int'(conv_start === 1'b1);
    touch_n <= touch_n + int'(touch_start === 1'b1);
    irq_n <= irq_n + int'(snooze_release_irq === 1'b1);
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until the rising edge where waitrequest is low;
  // state only moves in the update region, so the values read here are those the edge samples
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // a few cycles cover the model and edge detect latency
  task automatic pulse(input logic [3:0] k);
    @(posedge clock);
    fire <= k;
    @(posedge clock);
    fire <= 4'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wake();
    @(posedge clock);
    wake_irq <= 1'b1;
    @(posedge clock);
    wake_irq <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 1; i < 5; i++) begin
      bus(0, i == 4 ? 4'h9 : 4'(i), 0);
      chk("reset word", rd, 0);
    end
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      block_in <= cond[i];
      bus(1, `SSC_ADDR_CTRL, {30'h0, req[i]});
      bus(0, `SSC_ADDR_STAT, 0);
      chk("gate status", rd, {28'h0, st[i]});
      bus(1, `SSC_ADDR_STAT, 0);
      wake();
    end
    $display("test entry gate done");
    block_in <= '0; // every blocking condition cleared before standby requests
    for (int i = 0; i < 11; i++) begin
      w = tbl[i];
      bus(1, `SSC_ADDR_OPER, {16'h0, w[31:16]});
      bus(0, `SSC_ADDR_OPER, 0);
      chk("oper", rd, {16'h0, w[31:16]});
      bus(1, `SSC_ADDR_CTRL, 1);
      bus(0, `SSC_ADDR_STAT, 0);
      chk("standby", rd, 4);
      c0 = conv_n;
      t0 = touch_n;
      pulse(w[15:12]);
      chk("snooze", power_state, SSC_SNOOZE);
      chk("xfer allow", snooze_xfer_allow, w[31]);
      chk("conv", conv_n - c0, w[1]);
      chk("touch", touch_n - t0, w[0]);
      pulse(w[11:8]);
      chk("exit", power_state, w[7:4]);
      wake();
      chk("run", power_state, SSC_RUN);
    end
    $display("test snooze modes done");
    bus(1, `SSC_ADDR_REL, 32'h4);
    c0 = irq_n;
    pulse(4'h3);
    chk("release", irq_n != c0, 1);
    bus(1, `SSC_ADDR_REL, 0);
    c0 = irq_n;
    pulse(4'h3);
    chk("no release", irq_n - c0, 0);
    $display("test release done");
    end_sim();
  end
endmodule
